/* File: rtl/boot_reset_supervisor.v */
// reset, boot selection, image check and watchdog supervisor
//
// Functional notes
// - chip stays in reset while the reset pin is low
// - all GPIO pins high impedance during reset
// - 750000 clocks after release, then GPIO pull resistors enable
// - boot starts at speed chosen by the two speed select pins
// - source bits 3:2 zero means no image, wait for JTAG boot
// - pattern 010: first tile boots link B, second via channel end 0
// - pattern 011: first tile boots SPI, second via channel end 0
// - pattern 110: both tiles enable links B,E-H, boot channel end 0
// - pattern 111: each tile boots from SPI independently
// - security bit 5 forces boot from OTP memory
// - image is length word then four times that many bytes
// - image ends with CRC word; magic value skips CRC check
// - hold reset until every supply reports good
// - brown-out forces reset, then restart as a cold start
// - 16-bit watchdog, 1 ms resolution, separate from real-time count
// - watchdog timeout programmable from 1 ms to 65 s
// - watchdog expiry without reload resets the device
// - reset cause shows whether last reset was a watchdog expiry
// - watchdog clocked only in the active power state
`timescale 1ns/10ps
`default_nettype none
`include "brs_defines.vh"
module boot_reset_supervisor #(
  parameter INIT_CYCLES = `BRS_INIT_CYCLES,
  parameter TICK_CYCLES = `BRS_TICK_CYCLES
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // pins from outside
  input wire resetPin_n,
  input wire [4:0] bootModePins,
  input wire allSuppliesGood,
  // configuration
  input wire [7:0] securityConfig,
  input wire active_power_state,
  input wire [15:0] wdtTimeout,
  input wire wdtEnable,
  input wire wdtReload,
  // boot image stream
  input wire imgValid,
  input wire [31:0] imgWord,
  input wire [31:0] crcCalc,
  // chip reset and gpio control
  output reg chipReset,
  output reg gpioHighZ,
  output reg gpioPullEnable,
  // boot decision
  output reg bootStart,
  output reg boot_speed_sel0,
  output reg boot_speed_sel1,
  output reg [2:0] bootSource,
  output reg first_processor_tileLinkB,
  output reg second_processor_tileLinksEH,
  output reg waitJtag,
  // image check
  output reg imgDone,
  output reg imgCrcOk,
  output reg imgCrcSkipped,
  // watchdog
  output reg [15:0] wdtCount,
  output reg resetByWatchdog
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire pinSync;
  wire supplySync;
  wire [4:0] modeSync;

  brs_sync2 #(.RESET_VAL(1'b0)) uSyncPin (
    .clk(ref_clk),
    .rst(rst),
    .din(resetPin_n),
    .dout(pinSync)
  );

  brs_sync2 #(.RESET_VAL(1'b0)) uSyncPwr (
    .clk(ref_clk),
    .rst(rst),
    .din(allSuppliesGood),
    .dout(supplySync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gMode
      brs_sync2 #(.RESET_VAL(1'b0)) uSyncMode (
        .clk(ref_clk),
        .rst(rst),
        .din(bootModePins[gi]),
        .dout(modeSync[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  reg wdtExpire;
  // pin low, supply fault or watchdog all force a full reset
  wire holdReset = !pinSync || !supplySync || wdtExpire;

  // ----------------------------------------------------------------
  // internal reset sequence counter
  // ----------------------------------------------------------------
  localparam ST_RESET = 2'h0;
  localparam ST_INIT = 2'h1;
  localparam ST_BOOT = 2'h2;
  localparam ST_RUN = 2'h3;

  reg [1:0] state;
  reg [1:0] next_state;
  wire initDone;
  wire [19:0] initCount;
  wire [19:0] initLimit = INIT_CYCLES[19:0] - 20'h00001;

  brs_counter #(.W(20)) uInitCnt (
    .clk(ref_clk),
    .rst(rst),
    .clear(state != ST_INIT),
    .en(state == ST_INIT),
    .limit(initLimit),
    .done(initDone),
    .count(initCount)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (!holdReset) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (initDone) begin
          next_state = ST_BOOT;
        end
      end
      ST_BOOT: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    if (holdReset) begin
      next_state = ST_RESET;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // chip reset and gpio
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chipReset <= 1'b1;
      gpioHighZ <= 1'b1;
      gpioPullEnable <= 1'b0;
    end else begin
      chipReset <= (next_state == ST_RESET) || (next_state == ST_INIT);
      gpioHighZ <= (next_state == ST_RESET) || (next_state == ST_INIT);
      gpioPullEnable <= (next_state == ST_BOOT) || (next_state == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // boot selection, latched as the sequence ends
  // ----------------------------------------------------------------
  reg [2:0] next_src;
  always @* begin
    next_src = `BRS_SRC_RSVD;
    if (securityConfig[`BRS_OTP_BIT]) begin
      next_src = `BRS_SRC_OTP;
    end else if (modeSync[3:2] == 2'b00) begin
      next_src = `BRS_SRC_JTAG;
    end else if (modeSync[4:2] == 3'b010) begin
      next_src = `BRS_SRC_LINKB;
    end else if (modeSync[4:2] == 3'b011) begin
      next_src = `BRS_SRC_SPI_CHAIN;
    end else if (modeSync[4:2] == 3'b110) begin
      next_src = `BRS_SRC_LINKS_IND;
    end else if (modeSync[4:2] == 3'b111) begin
      next_src = `BRS_SRC_SPI_IND;
    end
  end

  wire bootNow = (state == ST_INIT) && (next_state == ST_BOOT);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bootStart <= 1'b0;
      boot_speed_sel0 <= 1'b0;
      boot_speed_sel1 <= 1'b0;
      bootSource <= `BRS_SRC_JTAG;
      first_processor_tileLinkB <= 1'b0;
      second_processor_tileLinksEH <= 1'b0;
      waitJtag <= 1'b0;
    end else if (holdReset) begin
      bootStart <= 1'b0;
      first_processor_tileLinkB <= 1'b0;
      second_processor_tileLinksEH <= 1'b0;
      waitJtag <= 1'b0;
    end else begin
      bootStart <= bootNow;
      if (bootNow) begin
        boot_speed_sel0 <= modeSync[0];
        boot_speed_sel1 <= modeSync[1];
        bootSource <= next_src;
        waitJtag <= (next_src == `BRS_SRC_JTAG);
        first_processor_tileLinkB <= (next_src == `BRS_SRC_LINKB) ||
          (next_src == `BRS_SRC_LINKS_IND);
        second_processor_tileLinksEH <=
          (next_src == `BRS_SRC_LINKS_IND);
      end
    end
  end

  // ----------------------------------------------------------------
  // boot image format check
  // ----------------------------------------------------------------
  localparam IM_IDLE = 2'h0;
  localparam IM_LEN = 2'h1;
  localparam IM_BODY = 2'h2;
  localparam IM_CRC = 2'h3;

  reg [1:0] imState;
  reg [31:0] imRemain;
  // loading only for sources that carry an image
  wire imgActive = (state == ST_RUN) && !waitJtag;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      imState <= IM_IDLE;
      imRemain <= 32'h00000000;
      imgDone <= 1'b0;
      imgCrcOk <= 1'b0;
      imgCrcSkipped <= 1'b0;
    end else if (!imgActive) begin
      imState <= IM_IDLE;
      imRemain <= 32'h00000000;
      imgDone <= 1'b0;
      imgCrcOk <= 1'b0;
      imgCrcSkipped <= 1'b0;
    end else begin
      case (imState)
        IM_IDLE: begin
          if (!imgDone) begin
            imState <= IM_LEN;
          end
        end
        IM_LEN: begin
          if (imgValid) begin
            imRemain <= imgWord;
            if (imgWord == 32'h00000000) begin
              imState <= IM_CRC;
            end else begin
              imState <= IM_BODY;
            end
          end
        end
        IM_BODY: begin
          if (imgValid) begin
            // one word carries four bytes of body
            imRemain <= imRemain - 32'h00000001;
            if (imRemain == 32'h00000001) begin
              imState <= IM_CRC;
            end
          end
        end
        default: begin
          if (imgValid) begin
            imgDone <= 1'b1;
            imgCrcSkipped <= (imgWord == `BRS_NO_CRC);
            imgCrcOk <= (imgWord == `BRS_NO_CRC) ||
              (imgWord == crcCalc);
            imState <= IM_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // 1 kHz tick and watchdog
  // ----------------------------------------------------------------
  reg [15:0] tickDiv;
  reg tick;
  wire wdtRun = (state == ST_RUN) && wdtEnable && active_power_state;
  wire [15:0] tickLimit = TICK_CYCLES[15:0] - 16'h0001;
  wire [15:0] loadVal = (wdtTimeout == 16'h0000) ? `BRS_WDT_MIN_MS :
    wdtTimeout;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickDiv <= 16'h0000;
      tick <= 1'b0;
    end else if (!wdtRun) begin
      tickDiv <= 16'h0000;
      tick <= 1'b0;
    end else if (tickDiv == tickLimit) begin
      tickDiv <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tickDiv <= tickDiv + 16'h0001;
      tick <= 1'b0;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdtCount <= `BRS_WDT_RESET;
      wdtExpire <= 1'b0;
    end else if (wdtExpire) begin
      wdtExpire <= 1'b0;
      wdtCount <= `BRS_WDT_RESET;
    end else if (state != ST_RUN || wdtReload || !wdtEnable) begin
      wdtCount <= loadVal;
    end else if (tick && active_power_state) begin
      if (wdtCount == 16'h0001) begin
        wdtExpire <= 1'b1;
        wdtCount <= 16'h0000;
      end else begin
        wdtCount <= wdtCount - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset cause
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resetByWatchdog <= 1'b0;
    end else if (wdtExpire) begin
      resetByWatchdog <= 1'b1;
    end else if (!pinSync || !supplySync) begin
      resetByWatchdog <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/brs_counter.v */
// clearable up counter that stops at its limit, with terminal flag
`timescale 1ns/10ps
`default_nettype none
module brs_counter #(
  parameter W = 20
) (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire en,
  input wire [W-1:0] limit,
  output wire done,
  output reg [W-1:0] count
);
  assign done = (count == limit);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (clear) begin
      count <= {W{1'b0}};
    end else if (en && !done) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* File: rtl/brs_defines.vh */
// timing counts, boot source encodings and image constants
`ifndef BRS_DEFINES_VH
`define BRS_DEFINES_VH

`define BRS_CLK_HZ 50000000
`define BRS_INIT_CYCLES 750000
`define BRS_TICK_MS 1
`define BRS_TICK_CYCLES ((`BRS_CLK_HZ / 1000) * `BRS_TICK_MS)
`define BRS_WDT_MIN_MS 16'h0001
`define BRS_WDT_RESET 16'hFFFF

`define BRS_SRC_JTAG 3'h0
`define BRS_SRC_RSVD 3'h1
`define BRS_SRC_LINKB 3'h2
`define BRS_SRC_SPI_CHAIN 3'h3
`define BRS_SRC_LINKS_IND 3'h4
`define BRS_SRC_SPI_IND 3'h5
`define BRS_SRC_OTP 3'h6

`define BRS_OTP_BIT 5
`define BRS_NO_CRC 32'h0D15AB1E

`endif

/* File: rtl/brs_sync2.v */
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module brs_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg stage1;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/brs_image_src.sv */
// boot image source model driving the image word stream
`timescale 1ns/10ps
`default_nettype none
module brs_image_src (
  // clock
  input wire ref_clk,
  // image stream
  output logic imgValid,
  output logic [31:0] imgWord
);
  initial begin
    imgValid = 1'b0;
    imgWord = 32'h0;
  end
  // one word per valid cycle, idle shows the inverse
  task automatic put(input logic [31:0] w, input int gap);
    begin
      @(posedge ref_clk);
      #1;
      imgValid = 1'b1;
      imgWord = w;
      @(posedge ref_clk);
      #1;
      imgValid = 1'b0;
      imgWord = ~w;
      repeat (gap) @(posedge ref_clk);
    end
  endtask
  task automatic send(input logic [31:0] n, input logic [31:0] crc);
    int i;
    begin
      put(n, $urandom_range(3));
      for (i = 0; i < n; i++) put($urandom, $urandom_range(3));
      put(crc, 0);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/brs_sva.sv */
// concurrent checks on the supervisor ports
`timescale 1ns/10ps
`default_nettype none
module brs_sva #(
  parameter INIT_CYCLES = 20
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // pins
  input wire resetPin_n,
  input wire allSuppliesGood,
  input wire active_power_state,
  // outputs watched
  input wire chipReset,
  input wire gpioHighZ,
  input wire gpioPullEnable,
  input wire bootStart,
  input wire [2:0] bootSource,
  input wire first_processor_tileLinkB,
  input wire second_processor_tileLinksEH,
  input wire waitJtag,
  input wire imgDone,
  input wire imgCrcOk,
  input wire imgCrcSkipped,
  input wire [15:0] wdtCount,
  input wire resetByWatchdog
);
  // length of the current reset stretch
  reg [31:0] runLen;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      runLen <= 32'h0;
    end else begin
      runLen <= chipReset ? runLen + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_holds_reset: assert property (!resetPin_n [*5] |-> chipReset)
    else $error("chip out of reset with pin low");
  a_highz_tracks: assert property (gpioHighZ == chipReset)
    else $error("gpio not high impedance in reset");
  a_pull_after_init: assert property (gpioPullEnable != chipReset)
    else $error("pull enable out of step with reset");
  a_init_length: assert property ($fell(chipReset) |->
    runLen >= INIT_CYCLES)
    else $error("internal reset too short");
  a_boot_pulse: assert property (bootStart |=> !bootStart)
    else $error("boot start longer than one cycle");
  a_jtag_idle: assert property (waitJtag |->
    bootSource == 3'h0 && !imgDone)
    else $error("image handled in jtag wait");
  a_linkb_src: assert property (first_processor_tileLinkB |->
    bootSource == 3'h2 || bootSource == 3'h4)
    else $error("link b on for wrong source");
  a_links_eh: assert property (second_processor_tileLinksEH |->
    bootSource == 3'h4 && first_processor_tileLinkB)
    else $error("internal links on for wrong source");
  a_crc_skip: assert property (imgCrcSkipped |-> imgCrcOk)
    else $error("skipped crc not reported good");
  a_supply_reset: assert property (!allSuppliesGood [*5] |->
    chipReset)
    else $error("chip out of reset on bad supply");
  a_wdt_cause: assert property ($rose(resetByWatchdog) |->
    ##[0:2] chipReset)
    else $error("watchdog cause without reset");
  a_wdt_frozen: assert property (!active_power_state && !chipReset &&
    !$past(active_power_state) |-> $stable(wdtCount))
    else $error("watchdog ran outside active state");
  c_boot: cover property (bootStart);
  c_wdt: cover property ($rose(resetByWatchdog));
  c_skip: cover property (imgCrcSkipped);
endmodule
bind boot_reset_supervisor brs_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
  .ref_clk(ref_clk),
  .rst(rst),
  .resetPin_n(resetPin_n),
  .allSuppliesGood(allSuppliesGood),
  .active_power_state(active_power_state),
  .chipReset(chipReset),
  .gpioHighZ(gpioHighZ),
  .gpioPullEnable(gpioPullEnable),
  .bootStart(bootStart),
  .bootSource(bootSource),
  .first_processor_tileLinkB(first_processor_tileLinkB),
  .second_processor_tileLinksEH(second_processor_tileLinksEH),
  .waitJtag(waitJtag),
  .imgDone(imgDone),
  .imgCrcOk(imgCrcOk),
  .imgCrcSkipped(imgCrcSkipped),
  .wdtCount(wdtCount),
  .resetByWatchdog(resetByWatchdog)
);
`default_nettype wire

/* File: tb/test_boot_reset_supervisor.sv */
// self-checking bench for the boot reset supervisor
`timescale 1ns/10ps
`default_nettype none
`include "brs_defines.vh"
module test_boot_reset_supervisor;
  localparam int INIT = 20;
  localparam int TICK = 5;
  logic ref_clk, rst, resetPin_n, allSuppliesGood, active_power_state;
  logic wdtEnable, wdtReload;
  logic [4:0] bootModePins;
  logic [7:0] securityConfig;
  logic [15:0] wdtTimeout;
  logic [31:0] crcCalc, w;
  wire imgValid, chipReset, gpioHighZ, gpioPullEnable, bootStart, waitJtag;
  wire boot_speed_sel0, boot_speed_sel1, imgDone, imgCrcOk, imgCrcSkipped;
  wire first_processor_tileLinkB, second_processor_tileLinksEH;
  wire resetByWatchdog;
  wire [2:0] bootSource;
  wire [15:0] wdtCount;
  wire [31:0] imgWord;
  wire [2:0] linkState = {first_processor_tileLinkB,
                          second_processor_tileLinksEH, waitJtag};
  int err_count = 0;
  int checks = 0;
  int i, n, lo;
  boot_reset_supervisor #(.INIT_CYCLES(INIT), .TICK_CYCLES(TICK)) DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .resetPin_n(resetPin_n),
    .bootModePins(bootModePins),
    .allSuppliesGood(allSuppliesGood),
    .securityConfig(securityConfig),
    .active_power_state(active_power_state),
    .wdtTimeout(wdtTimeout),
    .wdtEnable(wdtEnable),
    .wdtReload(wdtReload),
    .imgValid(imgValid),
    .imgWord(imgWord),
    .crcCalc(crcCalc),
    .chipReset(chipReset),
    .gpioHighZ(gpioHighZ),
    .gpioPullEnable(gpioPullEnable),
    .bootStart(bootStart),
    .boot_speed_sel0(boot_speed_sel0),
    .boot_speed_sel1(boot_speed_sel1),
    .bootSource(bootSource),
    .first_processor_tileLinkB(first_processor_tileLinkB),
    .second_processor_tileLinksEH(second_processor_tileLinksEH),
    .waitJtag(waitJtag),
    .imgDone(imgDone),
    .imgCrcOk(imgCrcOk),
    .imgCrcSkipped(imgCrcSkipped),
    .wdtCount(wdtCount),
    .resetByWatchdog(resetByWatchdog)
  );
  brs_image_src src (.ref_clk(ref_clk), .imgValid(imgValid), .imgWord(imgWord));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ----
  // helpers
  // ----
  task automatic tick(input int k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        err_count++;
        $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  function automatic logic [2:0] exp_src(input logic [4:0] p,
                                         input logic [7:0] s);
    if (s[5]) return 3'h6;
    case (p[4:2])
      3'h0, 3'h4: return 3'h0;
      3'h1, 3'h5: return 3'h1;
      3'h2: return 3'h2;
      3'h3: return 3'h3;
      3'h6: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction
  task automatic wait_boot(output int k);
    begin
      k = 0;
      while (bootStart !== 1'b1 && k < INIT + 40) begin
        tick(1);
        k++;
      end
    end
  endtask
  task automatic do_boot(input logic [4:0] p, input logic [7:0] s, bit mid);
    int k;
    logic [2:0] e;
    logic [2:0] lk;
    begin
      resetPin_n = 1'b0;
      bootModePins = p;
      securityConfig = s;
      tick(6);
      chk(chipReset, 1'b1);
      chk({gpioHighZ, gpioPullEnable}, 2'h2);
      resetPin_n = 1'b1;
      if (mid) begin
        tick(INIT / 2);
        resetPin_n = 1'b0;
        tick(4);
        resetPin_n = 1'b1;
      end
      wait_boot(k);
      chk(k >= INIT && k <= INIT + 6, 1'b1);
      e = exp_src(p, s);
      lk = {e == 3'h2 || e == 3'h4, e == 3'h4, e == 3'h0};
      tick(1);
      chk(bootSource, e);
      chk({boot_speed_sel1, boot_speed_sel0}, p[1:0]);
      chk(linkState, lk);
      chk({gpioHighZ, gpioPullEnable}, 2'h1);
    end
  endtask
  // ----
  // tests
  // ----
  initial begin
    rst = 1'b1;
    resetPin_n = 1'b1;
    allSuppliesGood = 1'b1;
    active_power_state = 1'b1;
    wdtEnable = 1'b0;
    wdtReload = 1'b0;
    wdtTimeout = 16'h0003;
    bootModePins = 5'h00;
    securityConfig = 8'h00;
    crcCalc = 32'h0;
    void'($urandom(42));
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // patterns 1 to 7, then 0, so the last boot waits for jtag
    for (i = 0; i < 8; i++) do_boot({3'(i + 1), 2'($urandom)}, 8'h00, i == 5);
    src.send(1, crcCalc);
    chk(imgDone, 1'b0);
    do_boot(5'($urandom), 8'h20, 0);
    $display("test boot sources done");
    for (i = 0; i < 3; i++) begin
      do_boot({3'h3, 2'($urandom)}, 8'h00, 0);
      tick(2);
      crcCalc = $urandom;
      w = (i == 0) ? crcCalc : (i == 1) ? `BRS_NO_CRC : ~crcCalc;
      src.send(i == 2 ? 0 : $urandom_range(4, 1), w);
      n = 0;
      while (imgDone !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      chk({imgDone, imgCrcOk, imgCrcSkipped}, {1'b1, i != 2, i == 1});
    end
    $display("test image done");
    wdtEnable = 1'b1;
    wdtReload = 1'b1;
    wdtTimeout = 16'h0000;
    tick(20);
    chk(wdtCount, 16'h0001);
    wdtTimeout = 16'($urandom_range(4, 1));
    tick(2);
    chk(wdtCount, wdtTimeout);
    active_power_state = 1'b0;
    wdtReload = 1'b0;
    w = wdtCount;
    tick(60);
    chk({resetByWatchdog, wdtCount}, w[15:0]);
    active_power_state = 1'b1;
    n = 0;
    while (resetByWatchdog !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    wdtEnable = 1'b0;
    lo = wdtTimeout * TICK;
    chk(n >= lo && n <= lo + 4, 1'b1);
    chk(chipReset, 1'b1);
    wait_boot(n);
    chk(resetByWatchdog, 1'b1);
    $display("test watchdog done");
    allSuppliesGood = 1'b0;
    tick(6);
    chk(chipReset, 1'b1);
    allSuppliesGood = 1'b1;
    wait_boot(n);
    chk(n >= INIT && n <= INIT + 6, 1'b1);
    chk(resetByWatchdog, 1'b0);
    $display("test brown-out done");
    report_and_stop;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
